// ### src/gate_eval_pkg.sv
// Shared constants, types and cost table for the cycle-scanned gate evaluator
package gate_eval_pkg;

	// ----------------------------------------------------------------
	// Resource sizes
	// ----------------------------------------------------------------
	localparam int NUM_SLOTS     = 16;
	localparam int NUM_IN        = 24;
	localparam int NUM_BASE_IN   = 8;
	localparam int NUM_OUT       = 16;
	localparam int NUM_BASE_OUT  = 4;
	localparam int NUM_BLANK     = 16;
	localparam int NUM_FLAG      = 24;
	localparam int STARTUP_IDX   = 7;
	localparam int NUM_SHIFT     = 8;
	localparam int NUM_KEY       = 4;
	localparam int NUM_AFLAG     = 6;
	localparam int NUM_AOUT      = 2;
	localparam int NUM_MOD_AIN   = 6;
	localparam int AWIDTH        = 10;
	localparam int NUM_SINK      = NUM_OUT + NUM_BLANK + NUM_FLAG;
	localparam int NUM_ASEL      = NUM_AFLAG + NUM_AOUT;

	// ----------------------------------------------------------------
	// Program memory limits
	// ----------------------------------------------------------------
	localparam logic [7:0]  BLOCK_LIMIT   = 8'h82;
	localparam logic [11:0] BYTE_CAPACITY = 12'h7d0;

	// ----------------------------------------------------------------
	// Digital source codes
	// ----------------------------------------------------------------
	localparam logic [7:0] SRC_OPEN      = 8'h00;
	localparam logic [7:0] SRC_HI        = 8'h01;
	localparam logic [7:0] SRC_LO        = 8'h02;
	localparam logic [7:0] SRC_IN        = 8'h10;
	localparam logic [7:0] SRC_IN_END    = 8'h28;
	localparam logic [7:0] SRC_FLAG      = 8'h30;
	localparam logic [7:0] SRC_FLAG_END  = 8'h48;
	localparam logic [7:0] SRC_SHIFT     = 8'h50;
	localparam logic [7:0] SRC_SHIFT_END = 8'h58;
	localparam logic [7:0] SRC_KEY       = 8'h58;
	localparam logic [7:0] SRC_KEY_END   = 8'h5c;
	localparam logic [7:0] SRC_BLOCK     = 8'h80;
	localparam logic [7:0] SRC_BLOCK_END = 8'h90;

	// ----------------------------------------------------------------
	// Analog source codes
	// ----------------------------------------------------------------
	localparam logic [3:0] ASRC_AIN      = 4'h0;
	localparam logic [3:0] ASRC_AIN_END  = 4'h8;
	localparam logic [3:0] ASRC_AFLAG    = 4'h8;
	localparam logic [3:0] ASRC_AFLAG_END = 4'he;

	// ----------------------------------------------------------------
	// Register offsets and fields
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_STATUS    = 12'h004;
	localparam logic [11:0] OFF_ADD_SRC   = 12'h008;
	localparam logic [11:0] OFF_ADD       = 12'h00c;
	localparam logic [11:0] OFF_BLOCK_OUT = 12'h010;
	localparam logic [11:0] OFF_FLAGS     = 12'h014;
	localparam logic [11:0] OFF_OUTPUTS   = 12'h018;
	localparam logic [11:0] OFF_SINK      = 12'h100;
	localparam logic [11:0] OFF_ASEL      = 12'h200;
	localparam logic [11:0] OFF_AFLAG     = 12'h240;
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_AMODE = 1;
	localparam int CTRL_CLEAR = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		GATE_AND       = 3'b000,
		GATE_AND_EDGE  = 3'b001,
		GATE_NAND      = 3'b010,
		GATE_NAND_EDGE = 3'b011,
		GATE_OR        = 3'b100,
		GATE_NOR       = 3'b101,
		GATE_XOR       = 3'b110,
		GATE_NOT       = 3'b111
	} gate_kind_t;

	typedef enum logic [1:0] {
		SCAN_IDLE   = 2'b00,
		SCAN_EVAL   = 2'b01,
		SCAN_COMMIT = 2'b10
	} scan_state_t;

	typedef struct packed {
		gate_kind_t      kind;
		logic [3:0]      inv;
		logic [3:0][7:0] src;
	} block_cfg_t;

	localparam block_cfg_t BLOCK_RESET = '{kind: GATE_AND, inv: 4'h0, src: 32'h0000_0000};

	// Program bytes taken by each basic block
	function automatic logic [11:0] block_cost(input gate_kind_t kind);
		logic [11:0] c;
		c = 12'h00c;
		if (kind == GATE_XOR) begin
			c = 12'h008;
		end else if (kind == GATE_NOT) begin
			c = 12'h004;
		end
		return c;
	endfunction : block_cost

endpackage : gate_eval_pkg

// ### src/gate_eval.sv
// Combinational evaluation of one basic block
`timescale 1ns/100ps
module gate_eval (
	input  wire logic                       edge_unused_i,
	input  wire gate_eval_pkg::gate_kind_t  kind_i,
	input  wire logic [3:0]                 inv_i,
	input  wire logic [3:0]                 raw_i,
	input  wire logic [3:0]                 conn_i,
	input  wire logic [3:0]                 prev_i,
	output logic                            out_o,
	output logic [3:0]                      eff_o
);

	logic def_level;
	logic all_one;
	logic any_one;
	logic prev_all;

	always_comb begin
		// RULE1 Open input high
		def_level = 1'b1;
		// RULE19 Open input low
		if (kind_i == gate_eval_pkg::GATE_OR || kind_i == gate_eval_pkg::GATE_NOR ||
				kind_i == gate_eval_pkg::GATE_XOR || kind_i == gate_eval_pkg::GATE_NOT) begin
			def_level = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			// RULE4 Per-input inversion
			eff_o[i] = conn_i[i] ? (raw_i[i] ^ inv_i[i]) : def_level;
		end
		all_one  = &eff_o;
		any_one  = |eff_o;
		prev_all = &prev_i;
		out_o    = edge_unused_i;
		case (kind_i)
			// RULE1 All inputs high
			gate_eval_pkg::GATE_AND:       out_o = all_one;
			// RULE2 Rising conjunction
			gate_eval_pkg::GATE_AND_EDGE:  out_o = all_one & ~prev_all;
			// RULE3 Negated conjunction
			gate_eval_pkg::GATE_NAND:      out_o = ~all_one;
			// RULE18 Falling negated conjunction
			gate_eval_pkg::GATE_NAND_EDGE: out_o = ~all_one & prev_all;
			// RULE19 Any input high
			gate_eval_pkg::GATE_OR:        out_o = any_one;
			// RULE20 All inputs low
			gate_eval_pkg::GATE_NOR:       out_o = ~any_one;
			// RULE21 Two inputs differ
			gate_eval_pkg::GATE_XOR:       out_o = eff_o[0] ^ eff_o[1];
			// RULE22 Inverse of input
			gate_eval_pkg::GATE_NOT:       out_o = ~eff_o[0];
			default:                       out_o = edge_unused_i;
		endcase
	end

endmodule : gate_eval

// ### src/block_budget.sv
// Block count and program byte budget with add refusal
`timescale 1ns/100ps
module block_budget (
	input  wire logic                      clock_i,
	input  wire logic                      reset_i,
	input  wire logic                      add_i,
	input  wire logic                      clear_i,
	input  wire gate_eval_pkg::gate_kind_t kind_i,
	output logic                           accept_o,
	output logic [7:0]                     count_o,
	output logic [11:0]                    bytes_o,
	output logic                           refused_o
);

	logic [11:0] bytes_next;
	logic        fits;

	always_comb begin
		bytes_next = bytes_o + gate_eval_pkg::block_cost(kind_i);
		// RULE17 Refuse when full
		fits = (count_o < 8'(gate_eval_pkg::NUM_SLOTS)) &&
			(count_o < gate_eval_pkg::BLOCK_LIMIT) &&
			(bytes_next <= gate_eval_pkg::BYTE_CAPACITY);
		accept_o = add_i & fits & ~clear_i;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i || clear_i) begin
			count_o <= 8'h00;
			bytes_o <= 12'h000;
		end else if (accept_o) begin
			count_o <= count_o + 8'h01;
			bytes_o <= bytes_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			refused_o <= 1'b0;
		end else if (add_i) begin
			// RULE17 Last attempt refused
			refused_o <= ~accept_o;
		end
	end

endmodule : block_budget

// ### src/cycle_logic_gate_evaluator.sv
// Top: APB registers, program store and scan sequencer
`timescale 1ns/100ps
//
// Summary of operation
// RULE1: AND high only when all inputs high
// RULE2: Edge AND fires when all-high begins
// RULE3: NAND low only when all inputs high
// RULE4: Each block input individually invertible
// RULE5: Startup flag reads one in first scan
// RULE6: Startup flag later acts as normal flag
// RULE7: Flags show previous scan value, held
// RULE8: Twenty-four digital and six analog flags
// RULE9: Shift-register bits are read-only sources
// RULE10: Sixteen blank outputs, never readable sources
// RULE11: Output indices: base outputs, then expansion
// RULE12: Input indices: base inputs, then expansion
// RULE13: Inputs seven, eight may be analog
// RULE14: Two analog outputs, analog sources only
// RULE15: Constant hi and lo sources
// RULE16: Four cursor keys usable as inputs
// RULE17: Refuse add beyond memory or count
// RULE18: Edge NAND fires when all-high breaks
// RULE19: OR high when any input high
// RULE20: NOR high only when all low
// RULE21: XOR high when two inputs differ
// RULE22: NOT inverts its input
// RULE23: Edge blocks keep previous inputs, cleared
module cycle_logic_gate_evaluator (
	input  wire logic                   clock_i,
	input  wire logic                   reset_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [11:0]            paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic      [31:0]            prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	input  wire logic [7:0]             base_in_i,
	input  wire logic [15:0]            exp_in_i,
	input  wire logic [1:0][9:0]        base_analog_i,
	input  wire logic [5:0][9:0]        mod_analog_i,
	input  wire logic [7:0]             shift_bits_i,
	input  wire logic [3:0]             cursor_keys_i,
	output logic      [3:0]             base_out_o,
	output logic      [11:0]            exp_out_o,
	output logic      [1:0][9:0]        analog_output_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	gate_eval_pkg::block_cfg_t  basic_block_list [gate_eval_pkg::NUM_SLOTS];
	logic [7:0]                 terminal_list [gate_eval_pkg::NUM_SINK];
	logic [3:0]                 asel_reg [gate_eval_pkg::NUM_ASEL];
	logic [9:0]                 analog_flag [gate_eval_pkg::NUM_AFLAG];
	logic [3:0]                 prev_reg [gate_eval_pkg::NUM_SLOTS];
	logic [15:0]                block_out_reg;
	logic [23:0]                flag_reg;
	logic [15:0]                out_reg;
	logic [15:0]                blank_reg;
	logic [31:0]                add_src_reg;
	logic                       run_reg;
	logic                       amode_reg;
	logic                       first_scan_reg;
	gate_eval_pkg::scan_state_t state_reg;
	logic [4:0]                 idx_reg;
	logic [23:0]                dig_in;
	logic [23:0]                flag_view;
	logic                       wr_en;
	logic                       rd_phase;
	logic                       add_pulse;
	logic                       clear_pulse;
	logic                       accept;
	logic [7:0]                 block_count;
	logic [11:0]                bytes_used;
	logic                       refused;
	gate_eval_pkg::block_cfg_t  cur_cfg;
	logic [3:0]                 cur_raw;
	logic [3:0]                 cur_conn;
	logic                       cur_out;
	logic [3:0]                 cur_eff;
	logic                       eval_now;

	// ----------------------------------------------------------------
	// Source fetch
	// ----------------------------------------------------------------
	// RULE12 Base inputs first
	assign dig_in    = {exp_in_i, base_in_i};
	// RULE5 Startup reads one
	assign flag_view = flag_reg | (24'(first_scan_reg) << gate_eval_pkg::STARTUP_IDX);

	function automatic logic src_bit(input logic [7:0] code);
		logic v;
		logic [7:0] k;
		v = 1'b0;
		k = 8'h00;
		// RULE15 Constant levels
		if (code == gate_eval_pkg::SRC_HI) begin
			v = 1'b1;
		end else if (code >= gate_eval_pkg::SRC_IN && code < gate_eval_pkg::SRC_IN_END) begin
			k = code - gate_eval_pkg::SRC_IN;
			// RULE13 Digital read off in analog mode
			v = dig_in[k[4:0]] & ~(amode_reg && (k == 8'h06 || k == 8'h07));
		end else if (code >= gate_eval_pkg::SRC_FLAG && code < gate_eval_pkg::SRC_FLAG_END) begin
			k = code - gate_eval_pkg::SRC_FLAG;
			// RULE7 Previous scan value
			v = flag_view[k[4:0]];
		end else if (code >= gate_eval_pkg::SRC_SHIFT && code < gate_eval_pkg::SRC_SHIFT_END) begin
			k = code - gate_eval_pkg::SRC_SHIFT;
			// RULE9 Read-only shift bits
			v = shift_bits_i[k[2:0]];
		end else if (code >= gate_eval_pkg::SRC_KEY && code < gate_eval_pkg::SRC_KEY_END) begin
			k = code - gate_eval_pkg::SRC_KEY;
			// RULE16 Cursor keys
			v = cursor_keys_i[k[1:0]];
		end else if (code >= gate_eval_pkg::SRC_BLOCK && code < gate_eval_pkg::SRC_BLOCK_END) begin
			k = code - gate_eval_pkg::SRC_BLOCK;
			v = block_out_reg[k[3:0]];
		end
		return v;
	endfunction : src_bit

	function automatic logic [9:0] analog_in(input logic [2:0] k);
		logic [9:0] v;
		v = 10'h000;
		// RULE13 Module inputs numbered after
		if (amode_reg) begin
			if (k < 3'h2) begin
				v = base_analog_i[k[0]];
			end else begin
				v = mod_analog_i[3'(k - 3'h2)];
			end
		end else if (k < 3'(gate_eval_pkg::NUM_MOD_AIN)) begin
			v = mod_analog_i[k];
		end
		return v;
	endfunction : analog_in

	// RULE14 Analog sources only
	function automatic logic [9:0] asrc(input logic [3:0] code);
		logic [9:0] v;
		logic [3:0] k;
		v = 10'h000;
		k = 4'h0;
		if (code < gate_eval_pkg::ASRC_AIN_END) begin
			v = analog_in(code[2:0]);
		end else if (code >= gate_eval_pkg::ASRC_AFLAG && code < gate_eval_pkg::ASRC_AFLAG_END) begin
			k = code - gate_eval_pkg::ASRC_AFLAG;
			v = analog_flag[k[2:0]];
		end
		return v;
	endfunction : asrc

	function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
			input int n);
		return (a >= base) && (a < base + 12'(4 * n));
	endfunction : in_range

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign rd_phase    = psel_i & ~penable_i;
	assign wr_en       = psel_i & penable_i & pready_o & pwrite_i;
	assign add_pulse   = wr_en && paddr_i == gate_eval_pkg::OFF_ADD;
	assign clear_pulse = wr_en && paddr_i == gate_eval_pkg::OFF_CTRL &&
		pwdata_i[gate_eval_pkg::CTRL_CLEAR];

	// Answer prepared in setup so every output stays a flop
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= rd_phase;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
			if (rd_phase) begin
				if (paddr_i == gate_eval_pkg::OFF_CTRL) begin
					prdata_o <= {30'h0, amode_reg, run_reg};
				end else if (paddr_i == gate_eval_pkg::OFF_STATUS) begin
					prdata_o <= {6'h0, first_scan_reg, refused, 4'h0, bytes_used, block_count};
					pslverr_o <= pwrite_i;
				end else if (paddr_i == gate_eval_pkg::OFF_ADD_SRC) begin
					prdata_o <= add_src_reg;
				end else if (paddr_i == gate_eval_pkg::OFF_ADD) begin
					prdata_o <= 32'h0000_0000;
				end else if (paddr_i == gate_eval_pkg::OFF_BLOCK_OUT) begin
					prdata_o <= {16'h0, block_out_reg};
					pslverr_o <= pwrite_i;
				end else if (paddr_i == gate_eval_pkg::OFF_FLAGS) begin
					prdata_o <= {8'h0, flag_view};
					pslverr_o <= pwrite_i;
				end else if (paddr_i == gate_eval_pkg::OFF_OUTPUTS) begin
					prdata_o <= {blank_reg, out_reg};
					pslverr_o <= pwrite_i;
				end else if (in_range(paddr_i, gate_eval_pkg::OFF_SINK, gate_eval_pkg::NUM_SINK)) begin
					prdata_o <= {24'h0, terminal_list[6'(12'(paddr_i - gate_eval_pkg::OFF_SINK) >> 2)]};
				end else if (in_range(paddr_i, gate_eval_pkg::OFF_ASEL, gate_eval_pkg::NUM_ASEL)) begin
					prdata_o <= {28'h0, asel_reg[3'(12'(paddr_i - gate_eval_pkg::OFF_ASEL) >> 2)]};
				end else if (in_range(paddr_i, gate_eval_pkg::OFF_AFLAG, gate_eval_pkg::NUM_AFLAG)) begin
					prdata_o <= {22'h0, analog_flag[3'(12'(paddr_i - gate_eval_pkg::OFF_AFLAG) >> 2)]};
					pslverr_o <= pwrite_i;
				end else begin
					pslverr_o <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			run_reg     <= 1'b0;
			amode_reg   <= 1'b0;
			add_src_reg <= 32'h0000_0000;
		end else if (wr_en) begin
			if (paddr_i == gate_eval_pkg::OFF_CTRL) begin
				run_reg   <= pwdata_i[gate_eval_pkg::CTRL_RUN];
				amode_reg <= pwdata_i[gate_eval_pkg::CTRL_AMODE];
			end else if (paddr_i == gate_eval_pkg::OFF_ADD_SRC) begin
				add_src_reg <= pwdata_i;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			for (int s = 0; s < gate_eval_pkg::NUM_SINK; s++) begin
				terminal_list[s] <= gate_eval_pkg::SRC_OPEN;
			end
			for (int a = 0; a < gate_eval_pkg::NUM_ASEL; a++) begin
				asel_reg[a] <= 4'hf;
			end
		end else if (wr_en) begin
			if (in_range(paddr_i, gate_eval_pkg::OFF_SINK, gate_eval_pkg::NUM_SINK)) begin
				terminal_list[6'(12'(paddr_i - gate_eval_pkg::OFF_SINK) >> 2)] <= pwdata_i[7:0];
			end else if (in_range(paddr_i, gate_eval_pkg::OFF_ASEL, gate_eval_pkg::NUM_ASEL)) begin
				asel_reg[3'(12'(paddr_i - gate_eval_pkg::OFF_ASEL) >> 2)] <= pwdata_i[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Program store
	// ----------------------------------------------------------------
	block_budget budget (
		.clock_i   (clock_i),
		.reset_i   (reset_i),
		.add_i     (add_pulse),
		.clear_i   (clear_pulse),
		.kind_i    (gate_eval_pkg::gate_kind_t'(pwdata_i[2:0])),
		.accept_o  (accept),
		.count_o   (block_count),
		.bytes_o   (bytes_used),
		.refused_o (refused)
	);

	always_ff @(posedge clock_i) begin
		if (reset_i || clear_pulse) begin
			for (int b = 0; b < gate_eval_pkg::NUM_SLOTS; b++) begin
				basic_block_list[b] <= gate_eval_pkg::BLOCK_RESET;
			end
		end else if (accept) begin
			// RULE17 Append only if accepted
			basic_block_list[block_count[3:0]] <= '{kind: gate_eval_pkg::gate_kind_t'(pwdata_i[2:0]),
				inv: pwdata_i[7:4], src: add_src_reg};
		end
	end

	// ----------------------------------------------------------------
	// Scan sequencer
	// ----------------------------------------------------------------
	assign eval_now = state_reg == gate_eval_pkg::SCAN_EVAL && {3'h0, idx_reg} < block_count;
	assign cur_cfg  = basic_block_list[idx_reg[3:0]];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cur_raw[i]  = src_bit(cur_cfg.src[i]);
			cur_conn[i] = cur_cfg.src[i] != gate_eval_pkg::SRC_OPEN;
		end
	end

	gate_eval evaluator (
		.edge_unused_i (1'b0),
		.kind_i        (cur_cfg.kind),
		.inv_i         (cur_cfg.inv),
		.raw_i         (cur_raw),
		.conn_i        (cur_conn),
		.prev_i        (prev_reg[idx_reg[3:0]]),
		.out_o         (cur_out),
		.eff_o         (cur_eff)
	);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_reg <= gate_eval_pkg::SCAN_IDLE;
			idx_reg   <= 5'h00;
		end else begin
			case (state_reg)
				gate_eval_pkg::SCAN_IDLE: begin
					idx_reg <= 5'h00;
					if (run_reg) begin
						state_reg <= gate_eval_pkg::SCAN_EVAL;
					end
				end
				gate_eval_pkg::SCAN_EVAL: begin
					if (eval_now) begin
						idx_reg <= idx_reg + 5'h01;
					end else begin
						state_reg <= gate_eval_pkg::SCAN_COMMIT;
					end
				end
				default: state_reg <= gate_eval_pkg::SCAN_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i || clear_pulse) begin
			block_out_reg <= 16'h0000;
			// RULE23 Previous inputs cleared
			for (int b = 0; b < gate_eval_pkg::NUM_SLOTS; b++) begin
				prev_reg[b] <= 4'h0;
			end
		end else if (eval_now) begin
			block_out_reg[idx_reg[3:0]] <= cur_out;
			// RULE23 Keep this scan's inputs
			prev_reg[idx_reg[3:0]]      <= cur_eff;
		end
	end

	// Sinks change only at commit, so all reads within a scan agree
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			out_reg   <= 16'h0000;
			blank_reg <= 16'h0000;
			flag_reg  <= 24'h00_0000;
			for (int a = 0; a < gate_eval_pkg::NUM_AFLAG; a++) begin
				analog_flag[a] <= 10'h000;
			end
		end else if (state_reg == gate_eval_pkg::SCAN_COMMIT) begin
			for (int q = 0; q < gate_eval_pkg::NUM_OUT; q++) begin
				out_reg[q] <= src_bit(terminal_list[q]);
			end
			// RULE10 Blank sinks, no source code
			for (int x = 0; x < gate_eval_pkg::NUM_BLANK; x++) begin
				blank_reg[x] <= src_bit(terminal_list[gate_eval_pkg::NUM_OUT + x]);
			end
			// RULE8 RULE6 RULE7 Latch flags
			for (int f = 0; f < gate_eval_pkg::NUM_FLAG; f++) begin
				flag_reg[f] <= src_bit(terminal_list[gate_eval_pkg::NUM_OUT +
					gate_eval_pkg::NUM_BLANK + f]);
			end
			// RULE8 Analog flags
			for (int a = 0; a < gate_eval_pkg::NUM_AFLAG; a++) begin
				analog_flag[a] <= asrc(asel_reg[a]);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i || !run_reg) begin
			first_scan_reg <= 1'b1;
		end else if (state_reg == gate_eval_pkg::SCAN_COMMIT) begin
			// RULE5 Cleared after first scan
			first_scan_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Terminal outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			base_out_o      <= 4'h0;
			exp_out_o       <= 12'h000;
			analog_output_o <= 20'h0_0000;
		end else begin
			// RULE11 Base outputs first
			base_out_o <= out_reg[gate_eval_pkg::NUM_BASE_OUT-1:0];
			exp_out_o  <= out_reg[gate_eval_pkg::NUM_OUT-1:gate_eval_pkg::NUM_BASE_OUT];
			if (state_reg == gate_eval_pkg::SCAN_COMMIT) begin
				// RULE14 Two analog outputs
				for (int j = 0; j < gate_eval_pkg::NUM_AOUT; j++) begin
					analog_output_o[j] <= asrc(asel_reg[gate_eval_pkg::NUM_AFLAG + j]);
				end
			end
		end
	end

endmodule : cycle_logic_gate_evaluator

// ### bench/gate_eval_properties.sv
// Port checks for the gate evaluator
`timescale 1ns/100ps
module gate_eval_checker (
	input	wire logic		clock_i,
	input	wire logic		reset_i,
	input	wire logic		psel_i,
	input	wire logic		penable_i,
	input	wire logic		pwrite_i,
	input	wire logic [11:0]	paddr_i,
	input	wire logic [31:0]	prdata_o,
	input	wire logic		pready_o,
	input	wire logic		pslverr_o,
	input	wire logic [3:0]	base_out_o,
	input	wire logic [11:0]	exp_out_o,
	input	wire logic [1:0][9:0]	analog_output_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_rd(a); s_setup ##1 (psel_i && penable_i && !pwrite_i && paddr_i == a); endsequence
	a_ready_after_setup: assert property (s_setup |=> pready_o) else $error("no ready");
	a_ready_single: assert property (pready_o |=> !pready_o) else $error("long ready");
	a_error_with_ready: assert property (pslverr_o |-> pready_o) else $error("stray error");
	a_idle_data_zero: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray data");
	a_unmapped_refused: assert property (s_rd(12'h01c) |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped read");
	a_status_no_error: assert property (s_rd(gate_eval_pkg::OFF_STATUS) |-> !pslverr_o)
		else $error("status read error");
	a_status_read_only: assert property (s_setup ##1 (psel_i && pwrite_i
		&& paddr_i == gate_eval_pkg::OFF_STATUS) |-> pslverr_o) else $error("status written");
	a_reset_clears_out: assert property ($fell(reset_i) |-> base_out_o == 4'h0
		&& exp_out_o == 12'h000 && analog_output_o == 20'h00000) else $error("reset outputs");
	a_output_held: assert property ($changed(base_out_o) |=> $stable(base_out_o)[*2])
		else $error("output moved within scan");
endmodule : gate_eval_checker

// ### bench/field_terminals.sv
// Field terminal model: inputs, shift bits, keys, analog levels
`timescale 1ns/100ps
module field_terminals (
	input	wire logic		clock_i,
	input	wire logic [1:0]	level_i,
	output	logic [7:0]		base_in_o = 8'h00,
	output	logic [15:0]		exp_in_o = 16'h0000,
	output	logic [1:0][9:0]	base_analog_o = 20'h00000,
	output	logic [5:0][9:0]	mod_analog_o = 60'h0,
	output	logic [7:0]		shift_bits_o = 8'h00,
	output	logic [3:0]		cursor_keys_o = 4'h0
);
	always @(posedge clock_i) begin
		base_in_o <= {6'h00, level_i};
		exp_in_o <= {level_i, 14'h0000};
		base_analog_o <= {2{8'h00, ~level_i}};
		mod_analog_o <= {6{8'h00, level_i}};
		shift_bits_o <= {4{level_i}};
		cursor_keys_o <= {2{level_i}};
	end
endmodule : field_terminals

// ### bench/testbench.sv
// Self-checking bench for the gate evaluator
`timescale 1ns/100ps
module testbench;
	logic clock_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
	logic pready_o, pslverr_o, rerr;
	logic [3:0] base_out_o, cursor_keys_o;
	logic [11:0] exp_out_o;
	logic [1:0][9:0] analog_output_o, base_analog_o;
	logic [5:0][9:0] mod_analog_o;
	logic [7:0] base_in_o, shift_bits_o;
	logic [15:0] exp_in_o;
	logic [1:0] level_i = 2'h0;
	int errors = 0, num_checks = 0;
	always #50 clock_i = ~clock_i;
	field_terminals field_terminals_i (.*);
	cycle_logic_gate_evaluator cycle_logic_gate_evaluator_i (.*, .base_in_i(base_in_o),
		.exp_in_i(exp_in_o), .base_analog_i(base_analog_o), .mod_analog_i(mod_analog_o),
		.shift_bits_i(shift_bits_o), .cursor_keys_i(cursor_keys_o));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rdata = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic add(input gate_eval_pkg::gate_kind_t k, input logic [3:0] inv);
		apb(1'b1, gate_eval_pkg::OFF_ADD, {24'h000000, inv, 1'b0, k});
	endtask : add
	task automatic test_regs();
		apb(1'b0, gate_eval_pkg::OFF_STATUS, 32'h0);
		chk(rdata, 32'h0200_0000);
		apb(1'b0, 12'h01c, 32'h0);
		chk({rerr, rdata}, {1'b1, 32'h0});
		apb(1'b1, gate_eval_pkg::OFF_STATUS, 32'hff);
		chk({31'h0, rerr}, 32'h1);
		$display("regs done");
	endtask : test_regs
	task automatic test_gates();
		logic a, b, c, p;
		logic [8:0] e, seen;
		apb(1'b1, gate_eval_pkg::OFF_ADD_SRC, 32'h0000_1110);
		for (int k = 0; k < 8; k++) begin
			add(gate_eval_pkg::gate_kind_t'(k), 4'h0);
		end
		apb(1'b1, gate_eval_pkg::OFF_ADD_SRC, 32'h0001_1110);
		add(gate_eval_pkg::GATE_AND, 4'h1);
		apb(1'b1, gate_eval_pkg::OFF_SINK, 32'h80);
		apb(1'b1, gate_eval_pkg::OFF_SINK + 12'h004, 32'h50);
		apb(1'b1, gate_eval_pkg::OFF_SINK + 12'h008, 32'h58);
		apb(1'b1, gate_eval_pkg::OFF_SINK + 12'h03c, 32'h84);
		apb(1'b1, gate_eval_pkg::OFF_ASEL + 12'h018, 32'h0);
		apb(1'b1, gate_eval_pkg::OFF_CTRL, 32'h1);
		p = 1'b0;
		for (int v = 0; v < 5; v++) begin
			level_i <= 2'(v);
			seen = 9'h000;
			// Reads closer than one scan, so a one-scan pulse is seen
			repeat (12) begin
				apb(1'b0, gate_eval_pkg::OFF_BLOCK_OUT, 32'h0);
				seen |= rdata[8:0];
			end
			{b, a} = 2'(v);
			c = a & b;
			e = {~a & b, ~a, a ^ b, ~(a | b), a | b, 1'b0, ~c, 1'b0, c};
			chk(rdata, {23'h0, e});
			chk({30'h0, seen[3], seen[1]}, {30'h0, p & ~c, c & ~p});
			chk({30'h0, exp_out_o[11], base_out_o[0]}, {30'h0, a | b, c});
			chk({30'h0, base_out_o[2:1]}, {30'h0, a, a});
			chk({22'h0, analog_output_o[0]}, {30'h0, b, a});
			p = c;
		end
		apb(1'b1, gate_eval_pkg::OFF_CTRL, 32'h3);
		repeat (30) @(posedge clock_i);
		chk({22'h0, analog_output_o[0]}, 32'h3);
		$display("gates done");
	endtask : test_gates
	task automatic test_refuse();
		repeat (10) add(gate_eval_pkg::GATE_AND, 4'h0);
		apb(1'b0, gate_eval_pkg::OFF_STATUS, 32'h0);
		chk(rdata, 32'h0100_b410);
		$display("refuse done");
	endtask : test_refuse
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	initial begin
		repeat (5) @(posedge clock_i);
		reset_i <= 1'b0;
		test_regs();
		test_gates();
		test_refuse();
		results();
	end
	initial begin
		#400000;
		errors++;
		results();
	end
endmodule : testbench
bind cycle_logic_gate_evaluator gate_eval_checker gate_eval_checker_i (.*);
